// ===== core/rca_core.sv
// rca_core: fetch/execute datapath of the 8-bit core
// Functional notes
// - separate program and data buses
// - opcodes are twelve bits
// - twelve-bit fetch, one word per cycle
// - two-stage overlapped fetch and execute
// - single-cycle instructions except branches and taken skips
// - special registers mapped into data space
// - eight-bit alu: add, sub, shift, logic
// - arithmetic is two's complement
// - two operands: accumulator plus file/immediate
// - single operand: accumulator or file
// - eight-bit accumulator, not address mapped
// - alu updates carry, nibble carry, zero
// - subtraction carries act as borrows
// - write-only eight-bit prescaler configuration
// - config-load copies accumulator to configuration
// - reset sets configuration to all ones
module rca_core
  import rca_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // program memory bus
  output logic [8:0] prog_addr_o,
  input wire logic [11:0] prog_data_i,
  // configuration and status
  output logic [7:0] presc_cfg_o,
  output logic [7:0] acc_o,
  output logic carry_flag_o,
  output logic nibble_carry_flag_o,
  output logic zero_flag_o,
  output logic branch_flush_o
);

  import rca_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [8:0] pc_q;         // fetch address
  logic [8:0] pc_d;
  logic [11:0] ir_q;        // instruction in execute
  logic [11:0] ir_d;
  logic [7:0] acc_q;        // accumulator, no data address
  logic [7:0] presc_cfg_q;  // prescaler configuration
  logic [7:0] fsr_q;        // indirect pointer
  logic [2:0] flags_q;      // carry, nibble carry, zero
  logic [2:0] page_q;       // upper status bits
  logic [7:0] status_rd;    // status as read
  rca_state_t state_q;      // execute state
  rca_state_t state_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [4:0] f_field;      // file address field
  logic [4:0] f_addr;       // effective file address
  logic dest_file;          // result to file, else accumulator
  logic [7:0] lit;          // immediate byte
  logic [7:0] f_rd;         // file read value
  logic [7:0] rf_rd;        // general file read
  logic [7:0] opnd;         // second alu operand
  rca_alu_op_t alu_op;
  logic alu_en;             // alu result written back
  logic use_lit;            // immediate operand
  logic lit_to_acc;         // load literal form
  logic cfg_load;           // configuration load opcode
  logic skip_zero;          // bubble and refetch next if result zero
  logic bit_op;             // bit clear/set/test
  logic [1:0] bit_kind;
  logic [2:0] bit_sel;
  logic goto_op;
  logic call_op;
  logic ret_op;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic [7:0] bit_res;      // bit op result
  logic take_branch;        // taken branch or skip
  logic [8:0] branch_tgt;
  logic [8:0] stack_q [2];  // two-level return stack
  logic wr_en;              // file write
  logic [7:0] wr_data;
  logic exec_valid;         // execute slot holds real work

  assign f_field = ir_q[4:0];
  assign dest_file = ir_q[5];
  assign lit = ir_q[7:0];
  assign bit_sel = ir_q[7:5];
  assign exec_valid = (state_q == RCA_ST_RUN);

  // indirect access goes through the pointer
  assign f_addr = (f_field == RCA_ADDR_INDIRECT) ? fsr_q[4:0] : f_field;
  assign status_rd = {page_q, flags_q[RCA_FLAG_CARRY] ? 1'b0 : 1'b0, 1'b0, flags_q[RCA_FLAG_ZERO],
                      flags_q[RCA_FLAG_NIBBLE], flags_q[RCA_FLAG_CARRY]};

  // ---------------------------------------------------------------
  // data space read mux: special registers mapped with files
  // ---------------------------------------------------------------
  always_comb
  begin
    case (f_addr)
      RCA_ADDR_INDIRECT: f_rd = 8'h00;
      RCA_ADDR_PCL: f_rd = pc_q[7:0];
      RCA_ADDR_STATUS: f_rd = status_rd;
      RCA_ADDR_FSR: f_rd = fsr_q;
      default: f_rd = rf_rd;
    endcase
  end

  // ---------------------------------------------------------------
  // instruction decode of the twelve-bit word
  // ---------------------------------------------------------------
  always_comb
  begin
    alu_op = RCA_OP_PASS_B;
    alu_en = 1'b0;
    use_lit = 1'b0;
    lit_to_acc = 1'b0;
    cfg_load = 1'b0;
    skip_zero = 1'b0;
    bit_op = 1'b0;
    bit_kind = ir_q[9:8];
    goto_op = 1'b0;
    call_op = 1'b0;
    ret_op = 1'b0;
    casez (ir_q)
      12'b0000_0000_0010: cfg_load = 1'b1;
      12'b0000_001?_????: alu_op = RCA_OP_PASS_B; // move acc to file, touches no flag
      12'b0000_01??_????:
      begin
        alu_op = RCA_OP_CLR;
        alu_en = 1'b1;
      end
      12'b0000_10??_????:
      begin
        alu_op = RCA_OP_SUB;
        alu_en = 1'b1;
      end
      12'b0000_11??_????:
      begin
        alu_op = RCA_OP_DEC;
        alu_en = 1'b1;
      end
      12'b0001_00??_????:
      begin
        alu_op = RCA_OP_OR;
        alu_en = 1'b1;
      end
      12'b0001_01??_????:
      begin
        alu_op = RCA_OP_AND;
        alu_en = 1'b1;
      end
      12'b0001_10??_????:
      begin
        alu_op = RCA_OP_XOR;
        alu_en = 1'b1;
      end
      12'b0001_11??_????:
      begin
        alu_op = RCA_OP_ADD;
        alu_en = 1'b1;
      end
      12'b0010_00??_????: alu_en = 1'b1; // move file
      12'b0010_01??_????:
      begin
        alu_op = RCA_OP_COM;
        alu_en = 1'b1;
      end
      12'b0010_10??_????:
      begin
        alu_op = RCA_OP_INC;
        alu_en = 1'b1;
      end
      12'b0010_11??_????:
      begin
        alu_op = RCA_OP_DEC;
        alu_en = 1'b1;
        skip_zero = 1'b1;
      end
      12'b0011_00??_????:
      begin
        alu_op = RCA_OP_RRF;
        alu_en = 1'b1;
      end
      12'b0011_01??_????:
      begin
        alu_op = RCA_OP_RLF;
        alu_en = 1'b1;
      end
      12'b0011_10??_????:
      begin
        alu_op = RCA_OP_SWAP;
        alu_en = 1'b1;
      end
      12'b0011_11??_????:
      begin
        alu_op = RCA_OP_INC;
        alu_en = 1'b1;
        skip_zero = 1'b1;
      end
      12'b01??_????_????: bit_op = 1'b1;
      12'b1000_????_????:
      begin
        ret_op = 1'b1; // return with literal
        lit_to_acc = 1'b1;
      end
      12'b1001_????_????: call_op = 1'b1;
      12'b101?_????_????: goto_op = 1'b1;
      12'b1100_????_????: lit_to_acc = 1'b1;
      12'b1101_????_????:
      begin
        alu_op = RCA_OP_OR;
        use_lit = 1'b1;
        lit_to_acc = 1'b1;
      end
      12'b1110_????_????:
      begin
        alu_op = RCA_OP_AND;
        use_lit = 1'b1;
        lit_to_acc = 1'b1;
      end
      12'b1111_????_????:
      begin
        alu_op = RCA_OP_XOR;
        use_lit = 1'b1;
        lit_to_acc = 1'b1;
      end
      default: alu_op = RCA_OP_PASS_B;
    endcase
  end

  // second operand: immediate or file register
  assign opnd = use_lit ? lit : f_rd;

  // ---------------------------------------------------------------
  // alu and file registers
  // ---------------------------------------------------------------
  rca_alu u_alu (
    .acc_i(acc_q),
    .opnd_i(opnd),
    .carry_i(flags_q[RCA_FLAG_CARRY]),
    .op_i(alu_op),
    .res_o(alu_res),
    .carry_o(alu_c),
    .nibble_o(alu_dc),
    .zero_o(alu_z),
    .carry_upd_o(upd_c),
    .nibble_upd_o(upd_dc),
    .zero_upd_o(upd_z)
  );

  // move acc to file passes the accumulator, bit set/clear the bit result, other ops the alu result
  assign wr_data = (ir_q[11:5] == 7'b0000_001) ? acc_q : (bit_op ? bit_res : alu_res);
  assign bit_res = (bit_kind == 2'b00) ? (f_rd & ~(8'h01 << bit_sel)) : (f_rd | (8'h01 << bit_sel));
  assign wr_en = exec_valid && (((alu_en && dest_file) || (ir_q[11:5] == 7'b0000_001))
                 || (bit_op && !bit_kind[1])) && (f_addr > RCA_ADDR_FSR);

  rca_regfile u_rf (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .we_i(wr_en),
    .waddr_i(f_addr),
    .wdata_i(wr_data),
    .raddr_i(f_addr),
    .rdata_o(rf_rd)
  );

  // ---------------------------------------------------------------
  // branch resolution
  // ---------------------------------------------------------------
  always_comb
  begin
    take_branch = 1'b0;
    branch_tgt = pc_q;
    if (exec_valid)
    begin
      if (goto_op)
      begin
        take_branch = 1'b1;
        branch_tgt = ir_q[8:0];
      end
      else if (call_op)
      begin
        take_branch = 1'b1;
        branch_tgt = {1'b0, ir_q[7:0]};
      end
      else if (ret_op)
      begin
        take_branch = 1'b1;
        branch_tgt = stack_q[0];
      end
      else if (skip_zero && alu_z)
        take_branch = 1'b1; // skip costs the bubble too
      else if (bit_op && bit_kind[1] && (f_rd[bit_sel] == bit_kind[0]))
        take_branch = 1'b1;
      else if (wr_en_special(RCA_ADDR_PCL))
      begin
        take_branch = 1'b1; // any write to the pc low byte jumps, unless a zero-result skip is taken first
        branch_tgt = {1'b0, wr_data};
      end
    end
  end

  // ---------------------------------------------------------------
  // fetch: one word per cycle on its own bus
  // ---------------------------------------------------------------
  always_comb
  begin
    pc_d = pc_q + 9'h001;
    ir_d = prog_data_i;
    state_d = RCA_ST_RUN;
    if (take_branch)
    begin
      pc_d = branch_tgt;
      ir_d = RCA_NOP_WORD;
      state_d = RCA_ST_FLUSH;
    end
  end

  assign prog_addr_o = pc_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_q <= RCA_PC_RST;
      ir_q <= RCA_NOP_WORD;
      state_q <= RCA_ST_RUN;
    end
    else
    begin
      pc_q <= pc_d;
      ir_q <= ir_d;
      state_q <= state_d;
    end
  end

  // return stack
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stack_q[0] <= RCA_PC_RST;
      stack_q[1] <= RCA_PC_RST;
    end
    else if (exec_valid && call_op)
    begin
      stack_q[0] <= pc_q;
      stack_q[1] <= stack_q[0];
    end
    else if (exec_valid && ret_op)
      stack_q[0] <= stack_q[1];
  end

  // ---------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      acc_q <= RCA_ACC_RST;
    else if (exec_valid && lit_to_acc)
      acc_q <= use_lit ? alu_res : lit;
    else if (exec_valid && alu_en && !dest_file && (ir_q[11:5] != 7'b0000_001))
      acc_q <= alu_res;
  end

  // ---------------------------------------------------------------
  // status flags and special registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flags_q <= 3'h0;
      page_q <= 3'h0;
    end
    else if (exec_valid)
    begin
      if (upd_c && (alu_en || use_lit))
        flags_q[RCA_FLAG_CARRY] <= alu_c;
      if (upd_dc && alu_en)
        flags_q[RCA_FLAG_NIBBLE] <= alu_dc;
      if (upd_z && (alu_en || use_lit) && !skip_zero)
        flags_q[RCA_FLAG_ZERO] <= alu_z;
      if (wr_en_special(RCA_ADDR_STATUS))
        page_q <= wr_data[7:5];
    end
  end

  // true when this cycle writes the given special address
  function automatic logic wr_en_special(input logic [4:0] a);
    wr_en_special = exec_valid && (f_addr == a) &&
                    ((alu_en && dest_file) || (ir_q[11:5] == 7'b0000_001) || (bit_op && !bit_kind[1]));
  endfunction

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fsr_q <= 8'h00;
    else if (wr_en_special(RCA_ADDR_FSR))
      fsr_q <= wr_data;
  end

  // ---------------------------------------------------------------
  // prescaler configuration, loaded only from the accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      presc_cfg_q <= RCA_CFG_RST;
    else if (exec_valid && cfg_load)
      presc_cfg_q <= acc_q;
  end

  // outputs
  assign presc_cfg_o = presc_cfg_q;
  assign acc_o = acc_q;
  assign carry_flag_o = flags_q[RCA_FLAG_CARRY];
  assign nibble_carry_flag_o = flags_q[RCA_FLAG_NIBBLE];
  assign zero_flag_o = flags_q[RCA_FLAG_ZERO];
  assign branch_flush_o = (state_q == RCA_ST_FLUSH);

endmodule

// ===== shared/rca_pkg.sv
// rca_pkg: shared constants and types for the core execution datapath
package rca_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int RCA_DATA_W = 8;   // data word width
  localparam int RCA_INSTR_W = 12; // instruction word width
  localparam int RCA_PC_W = 9;     // program address width
  localparam int RCA_FADDR_W = 5;  // file register address width

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RCA_CFG_RST = 8'hFF;    // prescaler config after reset
  localparam logic [7:0] RCA_ACC_RST = 8'h00;    // accumulator after reset
  localparam logic [8:0] RCA_PC_RST = 9'h1FF;    // program counter after reset
  localparam logic [11:0] RCA_NOP_WORD = 12'h000; // pipeline bubble

  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int RCA_FLAG_CARRY = 0;  // carry / borrow bit
  localparam int RCA_FLAG_NIBBLE = 1; // nibble carry / digit borrow bit
  localparam int RCA_FLAG_ZERO = 2;   // zero result bit

  // ---------------------------------------------------------------
  // special register addresses in the data map
  // ---------------------------------------------------------------
  localparam logic [4:0] RCA_ADDR_INDIRECT = 5'h00; // indirect access port
  localparam logic [4:0] RCA_ADDR_PCL = 5'h02;      // program counter low byte
  localparam logic [4:0] RCA_ADDR_STATUS = 5'h03;   // status register
  localparam logic [4:0] RCA_ADDR_FSR = 5'h04;      // file select pointer

  // ---------------------------------------------------------------
  // alu operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RCA_OP_PASS_B = 4'h0,  // pass second operand
    RCA_OP_ADD = 4'h1,     // a + b
    RCA_OP_SUB = 4'h2,     // b - a
    RCA_OP_AND = 4'h3,     // a & b
    RCA_OP_OR = 4'h4,      // a | b
    RCA_OP_XOR = 4'h5,     // a ^ b
    RCA_OP_COM = 4'h6,     // ~b
    RCA_OP_INC = 4'h7,     // b + 1
    RCA_OP_DEC = 4'h8,     // b - 1
    RCA_OP_RLF = 4'h9,     // rotate left through carry
    RCA_OP_RRF = 4'hA,     // rotate right through carry
    RCA_OP_SWAP = 4'hB,    // swap nibbles
    RCA_OP_CLR = 4'hC      // zero
  } rca_alu_op_t;

  // ---------------------------------------------------------------
  // execute state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCA_ST_RUN = 2'b01,   // normal execute
    RCA_ST_FLUSH = 2'b10  // branch bubble
  } rca_state_t;

endpackage

// ===== core/rca_alu.sv
// rca_alu: 8-bit combinational alu with carry, nibble carry and zero
module rca_alu
  import rca_pkg::*;
(
  // operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  input wire logic carry_i,
  input wire rca_pkg::rca_alu_op_t op_i,
  // results
  output logic [7:0] res_o,
  output logic carry_o,
  output logic nibble_o,
  output logic zero_o,
  output logic carry_upd_o,
  output logic nibble_upd_o,
  output logic zero_upd_o
);

  // 9-bit sum a + b + cin, two's complement
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // low nibble sum carry-out
  function automatic logic nib_c(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    nib_c = s[4];
  endfunction

  // ---------------------------------------------------------------
  // operation select
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [8:0] s;
    s = 9'h000;
    res_o = 8'h00;
    carry_o = carry_i;
    nibble_o = 1'b0;
    carry_upd_o = 1'b0;
    nibble_upd_o = 1'b0;
    zero_upd_o = 1'b0;
    case (op_i)
      RCA_OP_PASS_B:
      begin
        res_o = opnd_i;
        zero_upd_o = 1'b1;
      end
      RCA_OP_ADD:
      begin
        s = add9(acc_i, opnd_i, 1'b0);
        res_o = s[7:0];
        carry_o = s[8];
        nibble_o = nib_c(acc_i, opnd_i, 1'b0);
        {carry_upd_o, nibble_upd_o, zero_upd_o} = 3'h7;
      end
      RCA_OP_SUB:
      begin
        // b + ~a + 1: carry set means no borrow
        s = add9(opnd_i, ~acc_i, 1'b1);
        res_o = s[7:0];
        carry_o = s[8];
        nibble_o = nib_c(opnd_i, ~acc_i, 1'b1);
        {carry_upd_o, nibble_upd_o, zero_upd_o} = 3'h7;
      end
      RCA_OP_AND:
      begin
        res_o = acc_i & opnd_i;
        zero_upd_o = 1'b1;
      end
      RCA_OP_OR:
      begin
        res_o = acc_i | opnd_i;
        zero_upd_o = 1'b1;
      end
      RCA_OP_XOR:
      begin
        res_o = acc_i ^ opnd_i;
        zero_upd_o = 1'b1;
      end
      RCA_OP_COM:
      begin
        res_o = ~opnd_i;
        zero_upd_o = 1'b1;
      end
      RCA_OP_INC:
      begin
        res_o = opnd_i + 8'h01;
        zero_upd_o = 1'b1;
      end
      RCA_OP_DEC:
      begin
        res_o = opnd_i - 8'h01;
        zero_upd_o = 1'b1;
      end
      RCA_OP_RLF:
      begin
        res_o = {opnd_i[6:0], carry_i};
        carry_o = opnd_i[7];
        carry_upd_o = 1'b1;
      end
      RCA_OP_RRF:
      begin
        res_o = {carry_i, opnd_i[7:1]};
        carry_o = opnd_i[0];
        carry_upd_o = 1'b1;
      end
      RCA_OP_SWAP: res_o = {opnd_i[3:0], opnd_i[7:4]};
      RCA_OP_CLR:
      begin
        res_o = 8'h00;
        zero_upd_o = 1'b1;
      end
      default: res_o = opnd_i;
    endcase
  end

  // zero flag follows the result
  assign zero_o = (res_o == 8'h00);

endmodule

// ===== core/rca_regfile.sv
// rca_regfile: general purpose file registers, one write port and one read port
module rca_regfile
  import rca_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // write port
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [4:0] raddr_i,
  output logic [7:0] rdata_o
);

  // storage array, 32 words
  logic [7:0] mem_q [32];

  // ---------------------------------------------------------------
  // write
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < 32; i++)
        mem_q[i] <= 8'h00;
    end
    else if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  // asynchronous read
  assign rdata_o = mem_q[raddr_i];

endmodule

// ===== sim/rca_rom_model.sv
// rca_rom_model: program memory model that answers the core's fetch bus
module rca_rom_model
  import rca_pkg::*;
(
  // fetch bus
  input wire logic [8:0] addr_i,
  output logic [11:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // one twelve-bit word per program address, loaded by the bench
  logic [11:0] mem [512];

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  // every word starts as a bubble so stray fetches do nothing
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = RCA_NOP_WORD;
  end

  // combinational read on its own bus, one whole word per cycle
  assign data_o = mem[addr_i];
endmodule

// ===== sim/rca_core_monitor.sv
// rca_core_monitor: concurrent checks on the ports of the core
module rca_core_monitor
  import rca_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // program bus
  input wire logic [8:0] prog_addr_o,
  input wire logic [11:0] prog_data_i,
  // state outputs
  input wire logic [7:0] presc_cfg_o,
  input wire logic [7:0] acc_o,
  input wire logic carry_flag_o,
  input wire logic nibble_carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic branch_flush_o
);
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_rst_values:
  assert property ($rose(arst_n_i) |-> presc_cfg_o == RCA_CFG_RST && acc_o == RCA_ACC_RST
    && prog_addr_o == RCA_PC_RST && !branch_flush_o) else $error("reset values wrong");
  chk_cfg_load:
  assert property (prog_data_i == 12'h002 ##1 !branch_flush_o |=> presc_cfg_o == $past(acc_o))
    else $error("config load did not copy accumulator");
  chk_cfg_hold:
  assert property (!$stable(presc_cfg_o) |-> $past(prog_data_i, 2) == 12'h002)
    else $error("config changed without load");
  chk_goto_target:
  assert property (prog_data_i[11:9] == 3'b101 ##1 !branch_flush_o |=>
    branch_flush_o && prog_addr_o == $past(prog_data_i[8:0], 2)) else $error("branch target or bubble wrong");
  chk_flush_single:
  assert property (branch_flush_o |=> !branch_flush_o) else $error("bubble longer than one cycle");
  chk_pc_step:
  assert property ((prog_data_i == 12'h000 || prog_data_i[11:8] == 4'hC) ##1 !branch_flush_o |=>
    prog_addr_o == $past(prog_addr_o) + 9'h001) else $error("fetch address did not step");
  chk_load_lit:
  assert property (prog_data_i[11:8] == 4'hC ##1 !branch_flush_o |=> acc_o == $past(prog_data_i[7:0], 2))
    else $error("literal load wrong");
  chk_flush_nop:
  assert property (branch_flush_o |=> $stable(acc_o) && $stable(presc_cfg_o) && $stable(carry_flag_o))
    else $error("discarded slot wrote state");
  chk_zero_logic:
  assert property (prog_data_i[11:8] >= 4'hD ##1 !branch_flush_o |=> zero_flag_o == (acc_o == 8'h00))
    else $error("zero flag wrong after logic op");

  // main scenarios reached
  cov_cfg: cover property (prog_data_i == 12'h002 ##1 !branch_flush_o);
  cov_flush: cover property (branch_flush_o);
  cov_zero: cover property (zero_flag_o && !carry_flag_o);
endmodule

bind rca_core rca_core_monitor u_mon (
  .ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i),
  .prog_addr_o(prog_addr_o),
  .prog_data_i(prog_data_i),
  .presc_cfg_o(presc_cfg_o),
  .acc_o(acc_o),
  .carry_flag_o(carry_flag_o),
  .nibble_carry_flag_o(nibble_carry_flag_o),
  .zero_flag_o(zero_flag_o),
  .branch_flush_o(branch_flush_o)
);

// ===== sim/rca_core_test.sv
// rca_core_test: self-checking bench running a small program on the core
`define CHECK_EQ(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

module rca_core_test;
  import rca_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic ref_clk_i; // core clock
  logic arst_n_i; // active low reset
  logic [8:0] prog_addr_o; // fetch address
  logic [11:0] prog_data_i; // fetched word
  logic [7:0] presc_cfg_o; // prescaler configuration
  logic [7:0] acc_o; // accumulator
  logic carry_flag_o; // carry / borrow
  logic nibble_carry_flag_o; // nibble carry
  logic zero_flag_o; // zero result
  logic branch_flush_o; // bubble cycle
  int bad_count = 0; // mismatches
  int comparisons = 0; // checks made
  int cycles = 0; // hang guard
  // program: literal, config load, store, add, sub, and, goto, or, config load, increment file, self loop
  localparam logic [11:0] PROG [16] = '{12'hC3C, 12'h002, 12'h025, 12'hCC8, 12'h1C5, 12'hC3D, 12'h085,
    12'hE00, 12'hA0C, 12'hC55, 12'hC66, 12'hC66, 12'hD81, 12'h002, 12'h285, 12'hA0F};

  // --------------------------------------------------------------
  // design and memory
  // --------------------------------------------------------------
  rca_core u_dut (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .prog_addr_o(prog_addr_o),
    .prog_data_i(prog_data_i),
    .presc_cfg_o(presc_cfg_o),
    .acc_o(acc_o),
    .carry_flag_o(carry_flag_o),
    .nibble_carry_flag_o(nibble_carry_flag_o),
    .zero_flag_o(zero_flag_o),
    .branch_flush_o(branch_flush_o)
  );
  rca_rom_model u_rom (
    .addr_i(prog_addr_o),
    .data_o(prog_data_i)
  );

  // 10 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  // print counts and verdict, then stop
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // wait, bounded, until a given word is being fetched
  task automatic wait_addr(input logic [8:0] a);
    int n;
    n = 0;
    while (prog_addr_o !== a && n < 100)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHECK_EQ(prog_addr_o, a)
  endtask

  // one instruction cycle later the next expected address is fetched
  task automatic adv(input logic [8:0] a);
    @(negedge ref_clk_i);
    `CHECK_EQ(prog_addr_o, a)
  endtask

  // accumulator and the three flags
  task automatic chk_alu(input logic [7:0] acc, input logic c, input logic dc, input logic z);
    `CHECK_EQ(acc_o, acc)
    `CHECK_EQ(carry_flag_o, c)
    `CHECK_EQ(nibble_carry_flag_o, dc)
    `CHECK_EQ(zero_flag_o, z)
  endtask

  // hold reset low for a number of cycles, check reset state, release
  task automatic do_reset(input int n);
    arst_n_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHECK_EQ(presc_cfg_o, 8'hFF)
    `CHECK_EQ(acc_o, 8'h00)
    `CHECK_EQ(prog_addr_o, 9'h1FF)
    @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
  endtask

  // hang guard, well above the few dozen cycles the run needs
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      conclude();
    end
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    arst_n_i = 1'b0;
    #1;
    for (int i = 0; i < 16; i++)
      u_rom.mem[i] = PROG[i];
    do_reset(10);
    $display("test reset values done");
    wait_addr(9'h002);
    chk_alu(8'h3C, 1'b0, 1'b0, 1'b0);
    adv(9'h003);
    `CHECK_EQ(presc_cfg_o, 8'h3C)
    $display("test config load done");
    adv(9'h004);
    adv(9'h005);
    adv(9'h006);
    chk_alu(8'h04, 1'b1, 1'b1, 1'b0);
    adv(9'h007);
    adv(9'h008);
    chk_alu(8'hFF, 1'b0, 1'b0, 1'b0);
    adv(9'h009);
    chk_alu(8'h00, 1'b0, 1'b0, 1'b1);
    $display("test alu flags done");
    adv(9'h00C);
    `CHECK_EQ(branch_flush_o, 1'b1)
    adv(9'h00D);
    `CHECK_EQ(branch_flush_o, 1'b0)
    adv(9'h00E);
    chk_alu(8'h81, 1'b0, 1'b0, 1'b0);
    `CHECK_EQ(presc_cfg_o, 8'h3C)
    adv(9'h00F);
    `CHECK_EQ(presc_cfg_o, 8'h81)
    adv(9'h010);
    chk_alu(8'h3D, 1'b0, 1'b0, 1'b0);
    adv(9'h00F);
    $display("test branch bubble done");
    @(posedge ref_clk_i);
    do_reset(3);
    wait_addr(9'h003);
    `CHECK_EQ(presc_cfg_o, 8'h3C)
    $display("test second reset done");
    conclude();
  end
endmodule
